// File: hdl/dffs_top.v
// Local design decisions: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - After reset the module clock is stopped; block sits in standby.
// - Register writes other than to the stop register are ignored while in standby.
// - Pixel source selects memory or blending engine.
// - Output goes to main or sub display; sub is system-bus only.
// - Lines fetched per frame equal the vertical size.
// - Stride in bytes; bytes past image width are not displayed.
// - RGB uses one buffer; YCbCr uses luma and chroma buffers.
// - YCbCr to RGB uses BT.601, limited or full range.
// - Packing format 00010 selects 24-bit packed RGB888.
// - Mismatched formats pad low bits with zero or drop them.
// - RGB565 to RGB666 appends zero LSB to red and blue.
// - Byte, word, longword swaps enabled separately on read data.
// - Swap values 4, 7 and 6 suit the common RGB formats.
// - Fetch in raster order, restarting at base each frame.
`include "dffs_regs.vh"
module dffs_top (
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  output reg         mem_req_o,
  output reg  [31:0] mem_addr_o,
  input  wire        mem_ack_i,
  input  wire [63:0] mem_rdata_i,
  input  wire        mem_rvalid_i,
  input  wire [23:0] blend_pix_i,
  input  wire        blend_valid_i,
  output reg  [23:0] pix_o,
  output reg         pix_valid_o,
  output reg         pix_sub_o,
  output reg         pix_sysif_o,
  output reg         frame_start_o
);
  // ===================================================================
  // Reset synchroniser
  reg rst_s1;
  reg rst_s2;
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end
  wire rst_n = rst_s2;

  // ===================================================================
  // Registers
  reg        stop;
  reg [31:0] ctrl1;
  reg [31:0] ctrl2;
  reg [31:0] luma_start_address;
  reg [31:0] chroma_start_address;
  reg [31:0] line_stride_register;
  reg [31:0] data_format_register;
  reg [2:0]  input_swap_register;
  reg [10:0] hsize;
  reg [10:0] vsize;
  reg [10:0] line_cnt;
  reg        busy;
  wire       wr_ok = reg_wr_i & (!stop | (reg_addr_i == `DFFS_OFF_MSTOP));

  // Register writes, stop register always writable
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      stop                 <= `DFFS_RST_STOP;
      ctrl1                <= `DFFS_RST_WORD;
      ctrl2                <= `DFFS_RST_WORD;
      luma_start_address   <= `DFFS_RST_WORD;
      chroma_start_address <= `DFFS_RST_WORD;
      line_stride_register <= `DFFS_RST_WORD;
      data_format_register <= `DFFS_RST_WORD;
      input_swap_register  <= 3'h0;
      hsize                <= 11'h000;
      vsize                <= 11'h000;
    end else if (wr_ok) begin
      if (reg_addr_i == `DFFS_OFF_MSTOP) begin
        stop <= reg_wdata_i[`DFFS_STOP_BIT];
      end else if (reg_addr_i == `DFFS_OFF_CTRL1) begin
        ctrl1 <= reg_wdata_i;
      end else if (reg_addr_i == `DFFS_OFF_CTRL2) begin
        ctrl2 <= reg_wdata_i;
      end else if (reg_addr_i == `DFFS_OFF_LUMA) begin
        luma_start_address <= {3'h0, reg_wdata_i[28:3], 3'h0};
      end else if (reg_addr_i == `DFFS_OFF_CHROMA) begin
        chroma_start_address <= {3'h0, reg_wdata_i[28:3], 3'h0};
      end else if (reg_addr_i == `DFFS_OFF_STRIDE) begin
        line_stride_register <= {19'h00000, reg_wdata_i[12:3], 3'h0};
      end else if (reg_addr_i == `DFFS_OFF_FORMAT) begin
        data_format_register <= reg_wdata_i;
      end else if (reg_addr_i == `DFFS_OFF_SWAP) begin
        input_swap_register <= reg_wdata_i[2:0];
      end else if (reg_addr_i == `DFFS_OFF_HSIZE) begin
        hsize <= {reg_wdata_i[10:3], 3'h0};
      end else if (reg_addr_i == `DFFS_OFF_VSIZE) begin
        vsize <= reg_wdata_i[10:0];
      end
    end
  end

  // Read data, one cycle after the strobe
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `DFFS_OFF_MSTOP) begin
        reg_rdata_o <= {31'h0, stop};
      end else if (reg_addr_i == `DFFS_OFF_CTRL1) begin
        reg_rdata_o <= ctrl1;
      end else if (reg_addr_i == `DFFS_OFF_CTRL2) begin
        reg_rdata_o <= ctrl2;
      end else if (reg_addr_i == `DFFS_OFF_LUMA) begin
        reg_rdata_o <= luma_start_address;
      end else if (reg_addr_i == `DFFS_OFF_CHROMA) begin
        reg_rdata_o <= chroma_start_address;
      end else if (reg_addr_i == `DFFS_OFF_STRIDE) begin
        reg_rdata_o <= line_stride_register;
      end else if (reg_addr_i == `DFFS_OFF_FORMAT) begin
        reg_rdata_o <= data_format_register;
      end else if (reg_addr_i == `DFFS_OFF_SWAP) begin
        reg_rdata_o <= {29'h0, input_swap_register};
      end else if (reg_addr_i == `DFFS_OFF_HSIZE) begin
        reg_rdata_o <= {21'h0, hsize};
      end else if (reg_addr_i == `DFFS_OFF_VSIZE) begin
        reg_rdata_o <= {21'h0, vsize};
      end else if (reg_addr_i == `DFFS_OFF_STATUS) begin
        reg_rdata_o <= {20'h0, line_cnt, busy};
      end else begin
        reg_rdata_o <= 32'h0000_0000;
      end
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // ===================================================================
  // Mode decode
  wire       enable   = ctrl1[`DFFS_ENABLE_BIT] & !stop;
  wire       src_mem  = !ctrl2[`DFFS_SRC_BIT];
  wire [4:0] packing_format_field      = data_format_register[4:0];
  wire       is_ycc   = (packing_format_field == `DFFS_PKF_YCBCR);
  wire       is_24    = (packing_format_field == `DFFS_PKF_RGB888_24);
  wire       is_565   = (packing_format_field == `DFFS_PKF_RGB565);
  wire       full_rng = data_format_register[`DFFS_CVT_BIT];
  wire       panel_18 = ctrl1[3];
  wire       panel_16 = ctrl1[4];
  // Bytes per line actually holding pixels
  wire [12:0] line_bytes = is_565 ? {1'b0, hsize, 1'b0} :
                           is_24  ? ({2'b0, hsize} + {1'b0, hsize, 1'b0}) :
                           is_ycc ? {2'b0, hsize} : {hsize, 2'b0};

  // ===================================================================
  // Fetch sequencer: luma beat then chroma beat for YCbCr
  localparam ST_IDLE = 2'h0;
  localparam ST_REQ  = 2'h1;
  localparam ST_WAIT = 2'h2;
  reg [1:0]  state;
  reg [12:0] byte_off;
  reg        chroma_phase;
  reg [31:0] line_base;
  reg [31:0] cline_base;
  reg [63:0] luma_hold;

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state         <= ST_IDLE;
      busy          <= 1'b0;
      mem_req_o     <= 1'b0;
      mem_addr_o    <= 32'h0000_0000;
      byte_off      <= 13'h0000;
      line_cnt      <= 11'h000;
      chroma_phase  <= 1'b0;
      line_base     <= 32'h0000_0000;
      cline_base    <= 32'h0000_0000;
      frame_start_o <= 1'b0;
    end else begin
      frame_start_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          busy <= 1'b0;
          if (enable && src_mem && hsize != 11'h0 && vsize != 11'h0) begin
            line_base     <= luma_start_address;
            cline_base    <= chroma_start_address;
            byte_off      <= 13'h0000;
            line_cnt      <= 11'h000;
            chroma_phase  <= 1'b0;
            busy          <= 1'b1;
            frame_start_o <= 1'b1;
            state         <= ST_REQ;
          end
        end
        ST_REQ: begin
          mem_req_o  <= 1'b1;
          mem_addr_o <= (chroma_phase ? cline_base : line_base) +
                        {19'h0, byte_off};
          if (mem_req_o && mem_ack_i) begin
            mem_req_o <= 1'b0;
            state     <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (mem_rvalid_i) begin
            if (is_ycc && !chroma_phase) begin
              chroma_phase <= 1'b1;
              state        <= ST_REQ;
            end else begin
              chroma_phase <= 1'b0;
              state        <= ST_REQ;
              if (byte_off + 13'h8 >= line_bytes) begin
                byte_off  <= 13'h0000;
                line_base <= line_base + line_stride_register;
                if (line_cnt[0] | !is_ycc) begin
                  cline_base <= cline_base + line_stride_register;
                end
                line_cnt <= line_cnt + 11'h1;
                if (line_cnt + 11'h1 == vsize) begin
                  state <= ST_IDLE;
                end
              end else begin
                byte_off <= byte_off + 13'h8;
              end
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ===================================================================
  // Swap then unpack first pixel of each beat
  wire [63:0] swapped;
  dffs_swap dffs_swap_inst (
    .din_i  (mem_rdata_i),
    .en_i   (input_swap_register),
    .dout_o (swapped)
  );

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      luma_hold <= 64'h0;
    end else if (state == ST_WAIT && mem_rvalid_i && !chroma_phase) begin
      luma_hold <= swapped;
    end
  end

  // BT.601 conversion, fixed point x256
  reg signed [19:0] yy;
  reg signed [19:0] cb;
  reg signed [19:0] cr;
  reg signed [19:0] rr;
  reg signed [19:0] gg;
  reg signed [19:0] bb;
  reg [23:0]        next_pix;
  reg [7:0]         r8;
  reg [7:0]         g8;
  reg [7:0]         b8;
  function [7:0] dffs_clip;
    input signed [19:0] v;
    begin
      if (v < 20'sh00000) dffs_clip = 8'h00;
      else if (v > 20'sh0ff00) dffs_clip = 8'hff;
      else dffs_clip = v[15:8];
    end
  endfunction

  always @* begin
    yy = {12'h0, luma_hold[63:56]};
    cb = {12'h0, swapped[63:56]} - 20'sh00080;
    cr = {12'h0, swapped[55:48]} - 20'sh00080;
    if (!full_rng) begin
      yy = (yy - 20'sh00010) * 20'sh0012a;
      rr = yy + cr * 20'sh00199;
      gg = yy - cb * 20'sh00064 - cr * 20'sh000d0;
      bb = yy + cb * 20'sh00204;
    end else begin
      yy = yy * 20'sh00100;
      rr = yy + cr * 20'sh00167;
      gg = yy - cb * 20'sh00058 - cr * 20'sh000b7;
      bb = yy + cb * 20'sh001c6;
    end
    if (is_ycc) begin
      r8 = dffs_clip(rr);
      g8 = dffs_clip(gg);
      b8 = dffs_clip(bb);
    end else if (is_565) begin
      r8 = {swapped[63:59], 3'h0};
      g8 = {swapped[58:53], 2'h0};
      b8 = {swapped[52:48], 3'h0};
    end else if (is_24) begin
      r8 = swapped[63:56];
      g8 = swapped[55:48];
      b8 = swapped[47:40];
    end else begin
      r8 = swapped[55:48];
      g8 = swapped[47:40];
      b8 = swapped[39:32];
    end
    // Panel width truncation: 666 keeps 6, 565 keeps 5/6/5
    if (panel_18) begin
      next_pix = {r8[7:2], 2'h0, g8[7:2], 2'h0, b8[7:2], 2'h0};
    end else if (panel_16) begin
      next_pix = {r8[7:3], 3'h0, g8[7:2], 2'h0, b8[7:3], 3'h0};
    end else begin
      next_pix = {r8, g8, b8};
    end
  end

  // Pixel output and destination
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pix_o       <= 24'h000000;
      pix_valid_o <= 1'b0;
      pix_sub_o   <= 1'b0;
      pix_sysif_o <= 1'b0;
    end else begin
      pix_sub_o   <= ctrl1[`DFFS_DEST_BIT];
      pix_sysif_o <= ctrl1[`DFFS_DEST_BIT] | ctrl1[`DFFS_SYSIF_BIT];
      if (!src_mem) begin
        pix_valid_o <= blend_valid_i & enable;
        pix_o       <= blend_pix_i;
      end else begin
        pix_valid_o <= state == ST_WAIT && mem_rvalid_i &&
                       (chroma_phase || !is_ycc);
        pix_o       <= next_pix;
      end
    end
  end
endmodule // dffs_top

// File: hdl/dffs_regs.vh
`ifndef DFFS_REGS_VH
`define DFFS_REGS_VH
// =====================================================================
// Register offsets
`define DFFS_OFF_MSTOP   8'h00
`define DFFS_OFF_CTRL1   8'h04
`define DFFS_OFF_CTRL2   8'h08
`define DFFS_OFF_LUMA    8'h0c
`define DFFS_OFF_CHROMA  8'h10
`define DFFS_OFF_STRIDE  8'h14
`define DFFS_OFF_FORMAT  8'h18
`define DFFS_OFF_SWAP    8'h1c
`define DFFS_OFF_HSIZE   8'h20
`define DFFS_OFF_VSIZE   8'h24
`define DFFS_OFF_STATUS  8'h28
// =====================================================================
// Field positions
`define DFFS_STOP_BIT    0
`define DFFS_SRC_BIT     0
`define DFFS_DEST_BIT    0
`define DFFS_SYSIF_BIT   1
`define DFFS_ENABLE_BIT  2
`define DFFS_CVT_BIT     8
`define DFFS_SWAP_BYTE   0
`define DFFS_SWAP_WORD   1
`define DFFS_SWAP_LONG   2
// =====================================================================
// Packing format codes
`define DFFS_PKF_RGB888_32  5'h00
`define DFFS_PKF_RGB888_24  5'h02
`define DFFS_PKF_RGB565     5'h03
`define DFFS_PKF_YCBCR      5'h10
// =====================================================================
// Reset values
`define DFFS_RST_STOP    1'b1
`define DFFS_RST_WORD    32'h0000_0000
`endif

// File: hdl/dffs_swap.v
`timescale 1ns/10ps
// =====================================================================
// Byte, word and longword swap of one 64-bit memory beat
module dffs_swap (
  input  wire [63:0] din_i,
  input  wire [2:0]  en_i,
  output wire [63:0] dout_o
);
  wire [63:0] s_byte;
  wire [63:0] s_word;
  // Byte swap within each 16-bit word
  assign s_byte = en_i[0] ? {din_i[55:48], din_i[63:56], din_i[39:32],
                             din_i[47:40], din_i[23:16], din_i[31:24],
                             din_i[7:0],   din_i[15:8]} : din_i;
  // Word swap within each 32-bit longword
  assign s_word = en_i[1] ? {s_byte[47:32], s_byte[63:48],
                             s_byte[15:0],  s_byte[31:16]} : s_byte;
  // Longword swap
  assign dout_o = en_i[2] ? {s_word[31:0], s_word[63:32]} : s_word;
endmodule // dffs_swap

// File: dv/dffs_top_sva.sv
`timescale 1ns/10ps
`include "dffs_regs.vh"
// =====================================================================
// Port checker for the frame fetch block
module dffs_top_sva (
  input logic        core_clk_i,
  input logic        rst_n_i,
  input logic [7:0]  reg_addr_i,
  input logic [31:0] reg_wdata_i,
  input logic        reg_wr_i,
  input logic        reg_rd_i,
  input logic [31:0] reg_rdata_o,
  input logic        mem_req_o,
  input logic [31:0] mem_addr_o,
  input logic        mem_ack_i,
  input logic        mem_rvalid_i,
  input logic        pix_valid_o,
  input logic        pix_sub_o,
  input logic        pix_sysif_o,
  input logic        frame_start_o
);
  reg        stop, blend, pend;
  reg [31:0] luma;
  wire       wr_ok = reg_wr_i && !stop;
  // Shadow of stop bit, source select and luma base
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stop  <= 1'b1;
      blend <= 1'b0;
      pend  <= 1'b0;
      luma  <= 32'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == `DFFS_OFF_MSTOP)
        stop <= reg_wdata_i[`DFFS_STOP_BIT];
      if (wr_ok && reg_addr_i == `DFFS_OFF_CTRL2)
        blend <= reg_wdata_i[`DFFS_SRC_BIT];
      if (wr_ok && reg_addr_i == `DFFS_OFF_LUMA)
        luma <= reg_wdata_i;
      if (frame_start_o)
        pend <= 1'b1;
      else if (mem_req_o && mem_ack_i)
        pend <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_quiet;
    !mem_req_o && !pix_valid_o && !frame_start_o;
  endsequence
  sequence s_wait;
    mem_req_o && !mem_ack_i;
  endsequence
  reset_quiet_a: assert property ($rose(rst_n_i) |-> s_quiet [*2])
    else $error("fetch outputs active right after reset");
  standby_idle_a: assert property (stop |-> s_quiet)
    else $error("fetch activity while in standby");
  stop_read_a: assert property (reg_rd_i && reg_addr_i == 8'h00
    |=> reg_rdata_o[0] == stop) else $error("stop bit read wrong");
  req_hold_a: assert property (s_wait |=> mem_req_o
    && $stable(mem_addr_o)) else $error("request dropped before ack");
  addr_align_a: assert property (mem_req_o |-> mem_addr_o[2:0] == 3'h0
    && mem_addr_o[31:29] == 3'h0) else $error("fetch address misaligned");
  pix_beat_a: assert property (pix_valid_o && !blend
    |-> $past(mem_rvalid_i)) else $error("pixel without memory beat");
  blend_fetch_a: assert property (blend |-> !mem_req_o)
    else $error("memory fetch with blending source");
  sub_sys_a: assert property (pix_sub_o |-> pix_sysif_o)
    else $error("sub display without system bus");
  first_addr_a: assert property (pend && mem_req_o
    |-> mem_addr_o == luma) else $error("frame not started at base");
  frame_pulse_a: assert property (frame_start_o |=> !frame_start_o)
    else $error("frame start longer than one cycle");
endmodule // dffs_top_sva
bind dffs_top dffs_top_sva dffs_top_sva_inst (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o),
  .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i),
  .mem_rvalid_i(mem_rvalid_i), .pix_valid_o(pix_valid_o),
  .pix_sub_o(pix_sub_o), .pix_sysif_o(pix_sysif_o),
  .frame_start_o(frame_start_o));

// File: dv/dffs_mem_model.sv
`timescale 1ns/10ps
// =====================================================================
// Frame buffer memory: one 64-bit beat per accepted request
module dffs_mem_model (
  input  logic        clk_i,
  input  logic        rst_n_i,
  input  logic        req_i,
  input  logic [31:0] addr_i,
  input  logic [3:0]  dly_i,
  input  logic [31:0] split_i,
  input  logic [63:0] lo_i,
  input  logic [63:0] hi_i,
  output logic        ack_o,
  output logic        rvalid_o,
  output logic [63:0] rdata_o
);
  logic        busy;
  logic [3:0]  cnt;
  logic [31:0] adr;
  // Ack after dly_i cycles, data the cycle after ack
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy     <= 1'b0;
      cnt      <= 4'h0;
      adr      <= 32'h0;
      ack_o    <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o  <= 64'h0;
    end else begin
      ack_o    <= 1'b0;
      rvalid_o <= 1'b0;
      rdata_o  <= ~rdata_o; // No stale data outside a beat
      if (busy) begin
        busy     <= 1'b0;
        rvalid_o <= 1'b1;
        rdata_o  <= (adr >= split_i) ? hi_i : lo_i;
      end else if (req_i) begin
        if (cnt >= dly_i) begin
          ack_o <= 1'b1;
          busy  <= 1'b1;
          cnt   <= 4'h0;
          adr   <= addr_i;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule // dffs_mem_model

// File: dv/dffs_top_tb.sv
`timescale 1ns/10ps
`include "dffs_regs.vh"
module dffs_top_tb;
  reg         core_clk, rst_n, wr, rd, bvalid;
  reg  [7:0]  addr;
  reg  [31:0] wdata, v;
  reg  [23:0] bpix;
  reg  [3:0]  dly;
  reg  [63:0] lo;
  wire [31:0] rdata, maddr;
  wire [63:0] mdata;
  wire [23:0] pix;
  wire        req, ack, rvalid, pvalid, sub, sysif, fs;
  integer     n_fail, check_count, fs_cnt, i, top;
  reg  [31:0] aq[$];
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  dffs_top dffs_top_inst (.core_clk_i(core_clk), .rst_n_i(rst_n),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .mem_req_o(req), .mem_addr_o(maddr),
    .mem_ack_i(ack), .mem_rdata_i(mdata), .mem_rvalid_i(rvalid),
    .blend_pix_i(bpix), .blend_valid_i(bvalid), .pix_o(pix),
    .pix_valid_o(pvalid), .pix_sub_o(sub), .pix_sysif_o(sysif),
    .frame_start_o(fs));
  dffs_mem_model dffs_mem_model_inst (.clk_i(core_clk), .rst_n_i(rst_n),
    .req_i(req), .addr_i(maddr), .dly_i(dly), .split_i(32'h0000_8000),
    .lo_i(lo), .hi_i({8{8'h80}}), .ack_o(ack), .rvalid_o(rvalid),
    .rdata_o(mdata));
  // Log accepted fetch addresses and frame starts
  always @(posedge core_clk) begin
    if (req && ack) aq.push_back(maddr);
    if (fs) fs_cnt = fs_cnt + 1;
  end
  // ===================================================================
  // Tasks
  task results;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task timeout;
    n_fail = n_fail + 1;
    results;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    check_count = check_count + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wreg(input [7:0] a, input [31:0] d);
    @(posedge core_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task rreg(input [7:0] a, output [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task poll0(input [7:0] a);
    integer k;
    v = 32'h1;
    for (k = 0; k < 200 && v[0] !== 1'b0; k = k + 1)
      rreg(a, v);
    if (v[0] !== 1'b0) timeout;
  endtask
  task wait_pix(input [31:0] exp);
    integer k;
    #1;
    for (k = 0; k < 3000 && pvalid !== 1'b1; k = k + 1)
      @(posedge core_clk) #1;
    if (pvalid !== 1'b1) timeout;
    chk({8'h0, pix}, exp);
  endtask
  task fetch(input [31:0] fmt, input [2:0] sw, input [31:0] c1,
             input [63:0] d, input [3:0] dl, input [23:0] exp);
    @(posedge core_clk);
    lo  <= d;
    dly <= dl;
    fs_cnt = 0;
    wreg(`DFFS_OFF_FORMAT, fmt);
    wreg(`DFFS_OFF_SWAP, {29'h0, sw});
    wreg(`DFFS_OFF_CTRL1, c1 | 32'h4);
    wait_pix({8'h0, exp});
  endtask
  task drain;
    wreg(`DFFS_OFF_CTRL1, 32'h0);
    poll0(`DFFS_OFF_STATUS);
    repeat (4) @(posedge core_clk);
    aq.delete();
    $display("fetch test done");
  endtask
  // ===================================================================
  // Main sequence
  initial begin
    {rst_n, wr, rd, bvalid, addr, wdata, bpix, dly, lo} = 0;
    {n_fail, check_count, fs_cnt} = 0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rreg(`DFFS_OFF_MSTOP, v);
    chk(v, 32'h1);
    wreg(`DFFS_OFF_LUMA, 32'h2000);
    wreg(`DFFS_OFF_CTRL1, 32'h4);
    rreg(`DFFS_OFF_LUMA, v);
    chk(v, 32'h0);
    $display("standby test done");
    wreg(`DFFS_OFF_MSTOP, 32'h0);
    poll0(`DFFS_OFF_MSTOP);
    wreg(`DFFS_OFF_LUMA, 32'h1000);
    wreg(`DFFS_OFF_CHROMA, 32'h8000);
    wreg(`DFFS_OFF_STRIDE, 32'h40);
    wreg(`DFFS_OFF_HSIZE, 32'h8);
    wreg(`DFFS_OFF_VSIZE, 32'h3);
    rreg(`DFFS_OFF_LUMA, v);
    chk(v, 32'h1000);
    rreg(8'h3c, v);
    chk(v, 32'h0);
    $display("register test done");
    fetch(0, 4, 0, 64'h0011_2233_44aa_bbcc, 3, 24'haabbcc);
    for (i = 0; i < 5000 && fs_cnt < 2; i = i + 1) @(posedge core_clk);
    if (fs_cnt < 2) timeout;
    chk(aq[0], 32'h1000);
    top = 0;
    for (i = 0; i < aq.size(); i = i + 1) begin
      chk({31'h0, (aq[i] - 32'h1000) % 64 < 32}, 32'h1);
      if (i > 0) chk({31'h0, aq[i] > aq[i - 1]}, 32'h1);
      if ((aq[i] - 32'h1000) / 64 > top) top = (aq[i] - 32'h1000) / 64;
    end
    chk(top, 32'h2);
    drain;
    fetch(0, 2, 0, 64'h0011_2233_44aa_bbcc, 0, 24'h330011);
    drain;
    fetch(0, 1, 0, 64'h0011_2233_44aa_bbcc, 1, 24'h003322);
    drain;
    fetch(2, 7, 0, 64'h8877_6655_4433_2211, 0, 24'h112233);
    drain;
    fetch(3, 6, 32'h8, 64'h0000_0000_0000_ae6b, 2, 24'ha8cc58);
    drain;
    fetch(0, 4, 32'h10, 64'h0011_2233_44aa_bbcc, 0, 24'ha8b8c8);
    drain;
    fetch(0, 4, 32'h8, 64'h0011_2233_44aa_bbcc, 0, 24'ha8b8cc);
    drain;
    fetch(32'h110, 0, 0, {8{8'h5a}}, 0, 24'h5a5a5a);
    chk(aq[0], 32'h1000);
    chk(aq[1], 32'h8000);
    drain;
    fetch(32'h10, 0, 0, {8{8'h10}}, 2, 24'h000000);
    drain;
    wreg(`DFFS_OFF_CTRL2, 32'h1);
    wreg(`DFFS_OFF_CTRL1, 32'h4);
    @(posedge core_clk);
    bpix   <= 24'h123456;
    bvalid <= 1'b1;
    @(posedge core_clk);
    bvalid <= 1'b0;
    wait_pix(32'h123456);
    drain;
    wreg(`DFFS_OFF_CTRL2, 32'h0);
    for (i = 0; i < 4; i = i + 1) begin
      wreg(`DFFS_OFF_CTRL1, i);
      repeat (3) @(posedge core_clk);
      #1 chk({sysif, sub}, {i[0] | i[1], i[0]});
    end
    $display("destination test done");
    results;
  end
endmodule // dffs_top_tb
